// ---- hw/fesp_regs.sv ----
// The address map and the APB slave port are this design's own decisions.
module fesp_regs (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // flash core
   input  wire logic                  op_error_evt,
   input  wire logic                  subactive,
   input  wire logic [15:0]           erase_addr,
   output logic                       error_protect,
   output logic                       flash_powerdown,
   output logic [fesp_pkg::EB_COUNT-1:0] erase_sel_block,
   output logic                       erase_addr_hit,
   output logic [6:0]                 pe_ctrl_bits,
   output logic                       irq
);
   // ===========================================
   // apb decode
   fesp_pkg::fesp_apb_req_t req;
   logic wr_acc;
   logic rd_acc;
   logic gate_open;
   assign req       = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   // a write lands only at the edge where the access completes
   assign wr_acc    = req.sel && req.enable && req.write && pready;
   assign rd_acc    = req.sel && req.enable && !req.write;

   function automatic logic is_gated(input logic [7:0] a);
      is_gated = (a == fesp_pkg::OFF_PE_CTRL) || (a == fesp_pkg::OFF_PE_STATUS) ||
                 (a == fesp_pkg::OFF_EB_SEL) || (a == fesp_pkg::OFF_PWR_CTRL);
   endfunction : is_gated

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = is_gated(a) || (a == fesp_pkg::OFF_ACC_EN) || (a == fesp_pkg::OFF_IRQ_STAT) ||
                  (a == fesp_pkg::OFF_IRQ_CLR) || (a == fesp_pkg::OFF_IRQ_EN) ||
                  (a == fesp_pkg::OFF_CORE_STAT);
   endfunction : is_mapped

   function automatic logic in_block(input logic [15:0] a, input int b);
      in_block = (a >= fesp_pkg::EB_LO[b]) && (a <= fesp_pkg::EB_HI[b]);
   endfunction : in_block

   // ===========================================
   // registers
   logic       gate_r;
   logic       err_r;
   logic [6:0] pe_ctrl_r;
   logic [6:0] eb_r;
   logic       pd_inh_r;
   logic [fesp_pkg::IRQ_W-1:0] irq_stat_r;
   logic [fesp_pkg::IRQ_W-1:0] irq_en_r;
   fesp_pkg::fesp_pwr_t pwr_r;
   fesp_pkg::fesp_pwr_t pwr_nxt;

   logic sw_write_enable;
   logic gate_wr;
   logic [7:0] wbyte;
   logic eb_multi;
   logic eb_autoclr;
   assign gate_open = gate_r;
   assign sw_write_enable       = pe_ctrl_r[fesp_pkg::BIT_SWE];
   assign wbyte     = req.wdata[7:0];
   assign gate_wr   = wr_acc && gate_open;
   assign eb_multi  = !$onehot0(wbyte & fesp_pkg::EB_MASK);
   assign eb_autoclr = gate_wr && (req.addr == fesp_pkg::OFF_EB_SEL) && sw_write_enable && eb_multi;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gate_r <= 1'b0;
      end else if (wr_acc && req.addr == fesp_pkg::OFF_ACC_EN) begin
         gate_r <= wbyte[fesp_pkg::BIT_GATE];
      end
   end

   // error flag: only hardware sets it; status is never written
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_r <= 1'b0;
      end else if (op_error_evt) begin
         err_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pe_ctrl_r <= 7'h00;
      end else if (gate_wr && req.addr == fesp_pkg::OFF_PE_CTRL) begin
         // other bits only settable by a write that also sets write enable; a write with it clear clears all bits
         if (wbyte[fesp_pkg::BIT_SWE]) begin
            pe_ctrl_r <= wbyte[6:0];
         end else begin
            pe_ctrl_r <= 7'h00;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eb_r <= 7'h00;
      end else if (!sw_write_enable) begin
         eb_r <= 7'h00;
      end else if (gate_wr && req.addr == fesp_pkg::OFF_EB_SEL) begin
         eb_r <= eb_multi ? 7'h00 : wbyte[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pd_inh_r <= 1'b0;
      end else if (gate_wr && req.addr == fesp_pkg::OFF_PWR_CTRL) begin
         pd_inh_r <= wbyte[fesp_pkg::BIT_PD_INH];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_en_r <= '0;
      end else if (wr_acc && req.addr == fesp_pkg::OFF_IRQ_EN) begin
         irq_en_r <= wbyte[fesp_pkg::IRQ_W-1:0];
      end
   end

   // sticky events; a set in the clearing cycle wins
   logic [fesp_pkg::IRQ_W-1:0] evt;
   logic [fesp_pkg::IRQ_W-1:0] clr;
   assign evt = {eb_autoclr, op_error_evt && !err_r};
   assign clr = (wr_acc && req.addr == fesp_pkg::OFF_IRQ_CLR) ? wbyte[fesp_pkg::IRQ_W-1:0] : '0;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~clr) | evt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_stat_r & ~clr) | evt) & irq_en_r);
      end
   end

   // ===========================================
   // power mode
   always_comb begin
      case (pwr_r)
         fesp_pkg::PWR_NORMAL: pwr_nxt = !subactive ? fesp_pkg::PWR_NORMAL :
                                         (pd_inh_r ? fesp_pkg::PWR_HOLD : fesp_pkg::PWR_DOWN);
         fesp_pkg::PWR_DOWN:   pwr_nxt = subactive ? fesp_pkg::PWR_DOWN : fesp_pkg::PWR_NORMAL;
         fesp_pkg::PWR_HOLD:   pwr_nxt = subactive ? fesp_pkg::PWR_HOLD : fesp_pkg::PWR_NORMAL;
         default:              pwr_nxt = fesp_pkg::PWR_NORMAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwr_r <= fesp_pkg::PWR_NORMAL;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_powerdown <= 1'b0;
      end else begin
         flash_powerdown <= (pwr_nxt == fesp_pkg::PWR_DOWN);
      end
   end

   // ===========================================
   // core outputs
   // one range comparator per selection bit
   logic [fesp_pkg::EB_COUNT-1:0] blk_hit;
   logic                          hit_nxt;
   for (genvar g = 0; g < fesp_pkg::EB_COUNT; g++) begin : g_blk
      assign blk_hit[g] = eb_r[g] && in_block(erase_addr, g);
   end
   assign hit_nxt = |blk_hit;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         error_protect   <= 1'b0;
         erase_sel_block <= '0;
         erase_addr_hit  <= 1'b0;
         pe_ctrl_bits    <= 7'h00;
      end else begin
         error_protect   <= err_r || op_error_evt;
         erase_sel_block <= (err_r || op_error_evt) ? '0 : eb_r;
         erase_addr_hit  <= hit_nxt && !err_r;
         pe_ctrl_bits    <= (err_r || op_error_evt) ? 7'h00 : pe_ctrl_r;
      end
   end

   // ===========================================
   // read path, one wait state
   logic [7:0] rbyte;
   always_comb begin
      rbyte = fesp_pkg::ZERO8;
      case (req.addr)
         fesp_pkg::OFF_PE_CTRL:   rbyte = {1'b0, pe_ctrl_r};
         fesp_pkg::OFF_PE_STATUS: rbyte = {err_r, 7'h00};
         fesp_pkg::OFF_EB_SEL:    rbyte = {1'b0, eb_r};
         fesp_pkg::OFF_PWR_CTRL:  rbyte = {pd_inh_r, 7'h00};
         fesp_pkg::OFF_ACC_EN:    rbyte = {gate_r, 7'h00};
         fesp_pkg::OFF_IRQ_STAT:  rbyte = {6'h00, irq_stat_r};
         fesp_pkg::OFF_IRQ_EN:    rbyte = {6'h00, irq_en_r};
         fesp_pkg::OFF_CORE_STAT: rbyte = {5'h00, pwr_r};
         default:                 rbyte = fesp_pkg::ZERO8;
      endcase
      if (is_gated(req.addr) && !gate_open) begin
         rbyte = fesp_pkg::ZERO8;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= req.sel && req.enable && !pready;
         prdata  <= (rd_acc && !pready) ? {24'h00_0000, rbyte} : 32'h0000_0000;
         pslverr <= req.sel && req.enable && !pready && !is_mapped(req.addr);
      end
   end

   // ===========================================
   // checks
   sticky_err_a: assert property (@(posedge clk) disable iff (!rst_n)
      op_error_evt |=> err_r ##1 err_r)
      else $error("error flag not set or not held");

   protect_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      err_r |=> error_protect && erase_sel_block == '0 && pe_ctrl_bits == 7'h00)
      else $error("error protection not applied");

   eb_swe_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sw_write_enable |=> eb_r == 7'h00)
      else $error("erase select not cleared without write enable");

   eb_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
      $onehot0(eb_r))
      else $error("erase select holds more than one bit");

   pd_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_r == fesp_pkg::PWR_NORMAL && subactive && !pd_inh_r |=> flash_powerdown)
      else $error("power down not entered");

   pd_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_r == fesp_pkg::PWR_NORMAL && pd_inh_r |=> !flash_powerdown)
      else $error("power down entered while inhibited");

   gate_closed_a: assert property (@(posedge clk) disable iff (!rst_n)
      !gate_r && wr_acc && req.addr == fesp_pkg::OFF_PWR_CTRL |=> pd_inh_r == $past(pd_inh_r))
      else $error("gated register written while closed");

   gate_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_acc && !pready && !gate_r && is_gated(req.addr) |=> pready && prdata == 32'h0000_0000)
      else $error("gated read not zero");

   rsv_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_acc && !pready && req.addr == fesp_pkg::OFF_ACC_EN |=> prdata[6:0] == 7'h00)
      else $error("reserved bits not zero");

   status_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_acc && req.addr == fesp_pkg::OFF_PE_STATUS && !op_error_evt |=> err_r == $past(err_r))
      else $error("status register changed by a write");

   err_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      !err_r && !op_error_evt |=> !err_r)
      else $error("error flag set without an error");

   hit_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      err_r |=> !erase_addr_hit)
      else $error("block hit shown under error protection");

   rsv_status_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_acc && !pready && req.addr == fesp_pkg::OFF_PE_STATUS |=> prdata[6:0] == 7'h00)
      else $error("status reserved bits not zero");

   rsv_power_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_acc && !pready && req.addr == fesp_pkg::OFF_PWR_CTRL |=> prdata[6:0] == 7'h00)
      else $error("power control reserved bits not zero");

   eb_autoclr_a: assert property (@(posedge clk) disable iff (!rst_n)
      eb_autoclr |=> eb_r == 7'h00)
      else $error("multi-bit select write not cleared");

   blk_small_a: assert property (@(posedge clk) disable iff (!rst_n)
      eb_r[0] && in_block(erase_addr, 0) && !err_r |=> erase_addr_hit)
      else $error("first small block not hit");

   no_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      eb_r == 7'h00 |=> !erase_addr_hit)
      else $error("hit without a selected block");

   blk_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
      eb_r[4] && in_block(erase_addr, 4) && !err_r |=> erase_addr_hit)
      else $error("large block not hit");

   blk_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
      eb_r[5] && in_block(erase_addr, 5) && !err_r |=> erase_addr_hit)
      else $error("upper block not hit");

   blk_top_a: assert property (@(posedge clk) disable iff (!rst_n)
      eb_r[6] && in_block(erase_addr, 6) && !err_r |=> erase_addr_hit)
      else $error("top block not hit");

   eb_bit7_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_acc && !pready && req.addr == fesp_pkg::OFF_EB_SEL |=> !prdata[7])
      else $error("erase select bit 7 not zero");

   pd_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
      !subactive |=> !flash_powerdown)
      else $error("power down held outside subactive");

   pd_held_a: assert property (@(posedge clk) disable iff (!rst_n)
      pwr_r == fesp_pkg::PWR_HOLD |-> !flash_powerdown)
      else $error("power down shown in hold state");

   gate_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
      !gate_r && wr_acc && req.addr == fesp_pkg::OFF_PE_CTRL |=> pe_ctrl_r == $past(pe_ctrl_r))
      else $error("control register written while closed");

   ctrl_swe_a: assert property (@(posedge clk) disable iff (!rst_n)
      gate_wr && req.addr == fesp_pkg::OFF_PE_CTRL && !wbyte[fesp_pkg::BIT_SWE] |=> pe_ctrl_r == 7'h00)
      else $error("control bits kept without write enable");

   ctrl_noswe_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sw_write_enable |-> pe_ctrl_r == 7'h00)
      else $error("control bit set without write enable");

   gate_eb_a: assert property (@(posedge clk) disable iff (!rst_n)
      !gate_r && wr_acc && req.addr == fesp_pkg::OFF_EB_SEL && sw_write_enable |=> eb_r == $past(eb_r))
      else $error("erase select written while closed");

   irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      (irq_stat_r & irq_en_r) != '0 && clr == '0 |=> irq)
      else $error("interrupt not raised for enabled status");

   err_event_a: assert property (@(posedge clk) disable iff (!rst_n)
      op_error_evt && !err_r |=> irq_stat_r[fesp_pkg::IRQ_ERR])
      else $error("error event not recorded");

   pready_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready held longer than one cycle");

   slverr_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("slave error without ready");

   prdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside access");

   upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      prdata[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
endmodule : fesp_regs

// ---- hw/fesp_pkg.sv ----
package fesp_pkg;
   // ===========================================
   // register byte offsets on apb
   localparam logic [7:0] OFF_PE_CTRL   = 8'h00;
   localparam logic [7:0] OFF_PE_STATUS = 8'h04;
   localparam logic [7:0] OFF_EB_SEL    = 8'h08;
   localparam logic [7:0] OFF_PWR_CTRL  = 8'h0C;
   localparam logic [7:0] OFF_ACC_EN    = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
   localparam logic [7:0] OFF_IRQ_CLR   = 8'h18;
   localparam logic [7:0] OFF_IRQ_EN    = 8'h1C;
   localparam logic [7:0] OFF_CORE_STAT = 8'h20;

   // ===========================================
   // field positions
   localparam int BIT_ERR_FLAG = 7;
   localparam int BIT_SWE      = 6;
   localparam int BIT_PD_INH   = 7;
   localparam int BIT_GATE     = 7;
   localparam int EB_COUNT     = 7;
   localparam logic [7:0] PE_CTRL_MASK = 8'h7F;
   localparam logic [7:0] EB_MASK      = 8'h7F;
   localparam logic [7:0] ZERO8        = 8'h00;

   // interrupt bits: error set, erase select auto clear
   localparam int IRQ_ERR = 0;
   localparam int IRQ_EBC = 1;
   localparam int IRQ_W   = 2;

   // ===========================================
   // erase block address ranges
   localparam logic [15:0] EB_LO [EB_COUNT] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00,
                                                 16'h1000, 16'h8000, 16'hC000};
   localparam logic [15:0] EB_HI [EB_COUNT] = '{16'h03FF, 16'h07FF, 16'h0BFF, 16'h0FFF,
                                                 16'h7FFF, 16'hBFFF, 16'hDFFF};

   typedef enum logic [2:0] {
      PWR_NORMAL = 3'b001,
      PWR_DOWN   = 3'b010,
      PWR_HOLD   = 3'b100
   } fesp_pwr_t;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } fesp_apb_req_t;
endpackage : fesp_pkg

// ---- tb/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ===========================================
   // clock, reset and design inputs
   logic        clk          = 1'b0;
   logic        rst_n        = 1'b0;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [7:0]  paddr        = 8'h00;
   logic [31:0] pwdata       = 32'h0000_0000;
   logic        op_error_evt = 1'b0;
   logic        subactive    = 1'b0;
   logic [15:0] erase_addr   = 16'h0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        error_protect;
   logic        flash_powerdown;
   logic [6:0]  erase_sel_block;
   logic        erase_addr_hit;
   logic [6:0]  pe_ctrl_bits;
   logic        irq;
   logic [31:0] rd;
   logic        err_seen;
   int          err_total  = 0;
   int          n_compared = 0;
   int          cycles     = 0;
   // erase block bounds, one entry per selection bit
   logic [15:0] lo [7] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h8000, 16'hC000};
   logic [15:0] hi [7] = '{16'h03FF, 16'h07FF, 16'h0BFF, 16'h0FFF, 16'h7FFF, 16'hBFFF, 16'hDFFF};

   always #20 clk = ~clk;

   fesp_regs dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .op_error_evt(op_error_evt), .subactive(subactive), .erase_addr(erase_addr),
      .error_protect(error_protect), .flash_powerdown(flash_powerdown),
      .erase_sel_block(erase_sel_block), .erase_addr_hit(erase_addr_hit),
      .pe_ctrl_bits(pe_ctrl_bits), .irq(irq)
   );

   // ===========================================
   // checking and closing
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wrap_up;
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         wrap_up();
      end
   end

   // ===========================================
   // apb master
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("apb_ready", pready, 32'h0000_0001);
      rd       = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 8'h00);
      chk(name, rd, exp);
   endtask : rchk

   task automatic hit(input logic [15:0] a, input logic exp);
      @(posedge clk);
      erase_addr <= a;
      repeat (2) @(negedge clk);
      chk("addr_hit", erase_addr_hit, exp);
   endtask : hit

   // ===========================================
   // test sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rchk(8'h10, 32'h0000_0000, "acc_en_reset");
      for (int i = 0; i < 4; i++) begin
         wr(8'(i * 4), 8'hFF);
         rchk(8'(i * 4), 32'h0000_0000, "gated_read");
      end
      wr(8'h10, 8'hFF);
      rchk(8'h10, 32'h0000_0080, "acc_en");
      rchk(8'h00, 32'h0000_0000, "ctrl_kept");
      @(posedge clk);
      subactive <= 1'b1;
      repeat (3) @(negedge clk);
      chk("powerdown", flash_powerdown, 32'h0000_0001);
      @(posedge clk);
      subactive <= 1'b0;
      wr(8'h0C, 8'hFF);
      rchk(8'h0C, 32'h0000_0080, "pwr_ctrl");
      chk("pd_exit", flash_powerdown, 32'h0000_0000);
      subactive <= 1'b1;
      repeat (3) @(negedge clk);
      chk("powerdown", flash_powerdown, 32'h0000_0000);
      rchk(8'h20, 32'h0000_0004, "pwr_hold");
      subactive <= 1'b0;
      wr(8'h08, 8'h01);
      rchk(8'h08, 32'h0000_0000, "eb_no_swe");
      wr(8'h00, 8'h40);
      wr(8'h00, 8'h7F);
      rchk(8'h00, 32'h0000_007F, "ctrl");
      chk("ctrl_out", pe_ctrl_bits, 32'h0000_007F);
      for (int i = 0; i < 7; i++) begin
         wr(8'h08, 8'(1 << i));
         rchk(8'h08, 32'(1 << i), "eb_sel");
         chk("eb_out", erase_sel_block, 32'(1 << i));
         hit(lo[i], 1'b1);
         hit(hi[i], 1'b1);
         hit(hi[i] + 16'h0001, 1'b0);
      end
      wr(8'h08, 8'h80);
      rchk(8'h08, 32'h0000_0000, "eb_bit7");
      wr(8'h1C, 8'h03);
      wr(8'h08, 8'h03);
      rchk(8'h08, 32'h0000_0000, "eb_multi");
      rchk(8'h14, 32'h0000_0002, "irq_stat");
      chk("irq", irq, 32'h0000_0001);
      wr(8'h18, 8'h02);
      @(negedge clk);
      chk("irq_clr", irq, 32'h0000_0000);
      wr(8'h08, 8'h10);
      wr(8'h00, 8'h3F);
      rchk(8'h00, 32'h0000_0000, "ctrl_no_swe");
      rchk(8'h08, 32'h0000_0000, "eb_cleared");
      chk("eb_out", erase_sel_block, 32'h0000_0000);
      wr(8'h04, 8'hFF);
      rchk(8'h04, 32'h0000_0000, "status_ro");
      wr(8'h00, 8'h7F);
      @(posedge clk);
      op_error_evt <= 1'b1;
      @(posedge clk);
      op_error_evt <= 1'b0;
      rchk(8'h04, 32'h0000_0080, "status_err");
      chk("protect", error_protect, 32'h0000_0001);
      chk("irq_err", irq, 32'h0000_0001);
      wr(8'h08, 8'h01);
      repeat (2) @(negedge clk);
      chk("ctrl_prot", pe_ctrl_bits, 32'h0000_0000);
      chk("eb_prot", erase_sel_block, 32'h0000_0000);
      wr(8'h04, 8'h00);
      rchk(8'h04, 32'h0000_0080, "status_ro");
      apb(1'b0, 8'h40, 8'h00);
      chk("slverr", err_seen, 32'h0000_0001);
      chk("unmapped", rd, 32'h0000_0000);
      wr(8'h10, 8'h00);
      rchk(8'h04, 32'h0000_0000, "gated_status");
      wrap_up();
   end
endmodule : testbench
